//--- include/uat_params.svh
// Register offsets, bit positions, reset values and bit-timing counts of the serial port.
`ifndef UAT_PARAMS_SVH
`define UAT_PARAMS_SVH
`define UAT_A_SERIAL_CONTROL   8'h98
`define UAT_A_SERIAL_BUFFER   8'h99
`define UAT_A_T2CTL  8'hC8
`define UAT_A_RCAPL  8'hCA
`define UAT_A_RCAPH  8'hCB
`define UAT_A_CNTL   8'hCC
`define UAT_A_CNTH   8'hCD
`define UAT_SC_MHI    7
`define UAT_SC_MLO    6
`define UAT_SC_MP     5
`define UAT_SC_RXEN   4
`define UAT_SC_TX9    3
`define UAT_SC_RX9    2
`define UAT_SC_TXDONE 1
`define UAT_SC_RXDONE 0
`define UAT_T2_OVF    7
`define UAT_T2_EXT    6
`define UAT_T2_RXB    5
`define UAT_T2_TXB    4
`define UAT_T2_EXTEN  3
`define UAT_T2_RUN    2
`define UAT_T2_CTR    1
`define UAT_T2_CAPSEL 0
`define UAT_RST_SERIAL_CONTROL  8'h00
`define UAT_RST_T2CTL 8'h00
`define UAT_SUB_MID   4'h7
`define UAT_SUB_LAST  4'hF
`define UAT_M0_LAST   4'h7
`define UAT_STOP8     4'h9
`define UAT_STOP9     4'hA
`define UAT_CNT_MAX   16'hFFFF
`endif

//--- include/uat_pkg.sv
// Types shared by the serial port, its Timer 2 and the pin synchroniser.
package uat_pkg;
  // Serial modes in the order of the two mode select bits.
  typedef enum logic [1:0] {UAT_M_SHIFT, UAT_M_A8, UAT_M_F9, UAT_M_V9} uat_mode_t;
  // Register access strobes from the core.
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } uat_bus_t;
  // Pin levels: serial input, trigger input, count input.
  typedef struct packed {
    logic rxd;
    logic ext;
    logic t2in;
  } uat_pins_t;
  // Synchroniser stages.
  typedef struct packed {
    uat_pins_t s1;
    uat_pins_t s2;
  } uat_sync_t;
  // Timer 2 state, also its output bundle.
  typedef struct packed {
    logic [7:0]  con;
    logic [15:0] cnt;
    logic [15:0] rcap;
    logic        pre;
    logic        ovf;
  } uat_t2_t;
  // Serial port state.
  typedef struct packed {
    logic [7:0]  serial_control;
    logic [7:0]  rxbuf;
    logic [10:0] txsh;
    logic        tx_busy;
    logic [3:0]  tx_bit;
    logic [3:0]  tx_sub;
    logic        tx_half;
    logic        rx_busy;
    logic [3:0]  rx_bit;
    logic [3:0]  rx_sub;
    logic        rx_half;
    logic [8:0]  rxsh;
    uat_pins_t   pin_prev;
    logic        txd;
    logic        rxd_o;
    logic        rxd_oe;
    logic [7:0]  rdata;
    logic        irq_ser;
    logic        irq_t2;
  } uat_ser_t;
endpackage

//--- rtl/uat_sync.sv
// Two-stage synchroniser for the three input pins.
`timescale 1ns/1ps
module uat_sync import uat_pkg::*; (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  uat_pins_t pin_in,
  output uat_pins_t pin_out
);
  uat_sync_t s_ff;   // Both stages.
  uat_sync_t nxt_s;  // Next value of both stages.

  // Only the second stage is visible, so a metastable first stage never reaches logic.
  assign pin_out = s_ff.s2;

  // The second stage copies the first, the first copies the pins.
  always_comb begin
    nxt_s.s1 = pin_in;
    nxt_s.s2 = s_ff.s1;
  end

  // Idle lines are high, so reset to high to avoid a false falling edge.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '1;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end
endmodule

//--- rtl/uat_timer2.sv
// Timer 2: autoreload, capture and baud generator modes with trigger input.
`timescale 1ns/1ps
`include "uat_params.svh"
module uat_timer2 import uat_pkg::*; (
  input  wire logic mclk,
  input  wire logic nrst,
  input  wire logic ce,
  input  uat_bus_t  bus,
  input  wire logic ext_fall,
  input  wire logic cnt_fall,
  output uat_t2_t   t2
);
  uat_t2_t s_ff;    // Timer state.
  uat_t2_t nxt_s;   // Next timer state.
  logic    run;     // Timer running.
  logic    baud;    // Either baud select bit set.
  logic    cap;     // Capture mode in force.
  logic    inc;     // Count step this cycle.
  logic    wrap;    // Count rolls over this cycle.
  logic    ext_ev;  // Enabled trigger edge.

  assign t2 = s_ff;

  // Mode decode, counting, reload, capture, then writes, then flag sets.
  always_comb begin
    nxt_s = s_ff;
    nxt_s.ovf = 1'b0;
    run  = s_ff.con[`UAT_T2_RUN];
    baud = s_ff.con[`UAT_T2_RXB] | s_ff.con[`UAT_T2_TXB];
    cap  = s_ff.con[`UAT_T2_CAPSEL] & ~baud;
    // As a baud generator on the internal clock the timer steps every second clock.
    nxt_s.pre = run & baud & ~s_ff.pre;
    inc  = run & (s_ff.con[`UAT_T2_CTR] ? cnt_fall : (~baud | s_ff.pre));
    wrap = inc & (s_ff.cnt == `UAT_CNT_MAX);
    ext_ev = run & s_ff.con[`UAT_T2_EXTEN] & ext_fall;
    if (inc) begin
      nxt_s.cnt = s_ff.cnt + 16'h0001;
    end
    if (wrap) begin
      nxt_s.ovf = 1'b1;
      if (!cap) begin
        nxt_s.cnt = s_ff.rcap;
      end
    end
    // A trigger edge in baud mode only raises the flag.
    if (ext_ev && !baud) begin
      if (cap) begin
        nxt_s.rcap = s_ff.cnt;
      end else begin
        nxt_s.cnt = s_ff.rcap;
      end
    end
    // Software writes override the data registers.
    if (bus.wr) begin
      if (bus.addr == `UAT_A_T2CTL) begin
        nxt_s.con = bus.wdata;
      end else if (bus.addr == `UAT_A_RCAPL) begin
        nxt_s.rcap[7:0] = bus.wdata;
      end else if (bus.addr == `UAT_A_RCAPH) begin
        nxt_s.rcap[15:8] = bus.wdata;
      end else if (bus.addr == `UAT_A_CNTL) begin
        nxt_s.cnt[7:0] = bus.wdata;
      end else if (bus.addr == `UAT_A_CNTH) begin
        nxt_s.cnt[15:8] = bus.wdata;
      end
    end
    // Flag sets come last so an event beats a clear in the same cycle.
    if (wrap && !baud) begin
      nxt_s.con[`UAT_T2_OVF] = 1'b1;
    end
    if (ext_ev) begin
      nxt_s.con[`UAT_T2_EXT] = 1'b1;
    end
  end

  // State register; the clock enable freezes everything.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.con <= `UAT_RST_T2CTL;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_baud_no_ovf: assert property (ce && baud && !bus.wr && !s_ff.con[`UAT_T2_OVF] |=> !s_ff.con[`UAT_T2_OVF])
    else $error("overflow flag set in baud mode");
  chk_auto_reload: assert property (ce && wrap && !cap && !ext_ev && !bus.wr |=> s_ff.cnt == $past(s_ff.rcap))
    else $error("autoreload value wrong");
  chk_capture_copy: assert property (ce && ext_ev && cap && !bus.wr |=> s_ff.rcap == $past(s_ff.cnt) && s_ff.con[6])
    else $error("capture failed");
  chk_ext_reload: assert property (ce && ext_ev && !cap && !baud && !bus.wr |=> s_ff.cnt == $past(s_ff.rcap))
    else $error("trigger reload failed");
  cov_t2_wrap: cover property (ce && wrap && !baud);
endmodule

//--- rtl/uat_top.sv
// Serial port with shift and asynchronous modes; the 8-bit and variable 9-bit modes are clocked by Timer 1 or Timer 2.
// Operation
// - Timer 2 mode from run, baud, capture bits.
// - Autoreload rollover sets flag and reloads count.
// - Trigger edge in autoreload reloads, sets flag.
// - Capture mode counts freely, overflow flag set.
// - Trigger edge in capture copies count, flags.
// - Baud mode never sets the overflow flag.
// - Baud mode still sets the trigger flag.
// - Async transmit and receive run independently, simultaneously; shift receive waits for transmit idle.
// - New byte overwrites an unread received byte.
// - Buffer write starts transmit; read returns receive.
// - Mode bits pick shift, 8-bit, 9-bit framing.
// - 8-bit multiprocessor needs a valid stop bit.
// - 9-bit multiprocessor drops frames with ninth zero.
// - Receiver works only while receive enable set.
// - 9-bit frames send the programmed ninth bit.
// - Received ninth or stop bit is latched.
// - Transmit done at eighth bit or stop start.
// - Receive done at eighth bit or mid stop.
// - Async frame: start zero, LSB first, stop one.
// - Shift receive starts when done clear, enabled.
// - In 8-bit and variable 9-bit modes, baud select bits choose Timer 2 or Timer 1.
// - Timer 2 rate: sixteen overflows per bit.
`timescale 1ns/1ps
`include "uat_params.svh"
module uat_top import uat_pkg::*; (
  input  wire logic  mclk,
  input  wire logic  nrst,
  input  wire logic  ce,
  input  uat_bus_t   sfr,
  input  wire logic  t1_ovf,
  input  wire logic  smod,
  input  uat_pins_t  pins,
  output logic [7:0] sfr_rdata,
  output logic       txd_out,
  output logic       rxd_out,
  output logic       rxd_oe,
  output logic       irq_serial,
  output logic       irq_timer2
);
  uat_pins_t pin_s;     // Synchronised pins.
  uat_t2_t   t2;        // Timer 2 state.
  uat_ser_t  s_ff;      // Serial port state.
  uat_ser_t  nxt_s;     // Next serial port state.
  uat_mode_t mode;      // Current serial mode.
  logic      m0;        // Shift register mode.
  logic      nine;      // One of the 9-bit modes.
  logic [3:0] stop_at;  // Bit index of the stop bit.
  logic      ext_fall;  // Falling edge on the trigger pin.
  logic      cnt_fall;  // Falling edge on the count pin.
  logic      wr_serial_control;   // Control register write.
  logic      wr_serial_buffer;   // Buffer write.
  logic      src_tx;    // Transmit rate source pulse.
  logic      half_tx;   // Transmit rate halved.
  logic      tick_tx;   // Transmit sixteenth-bit tick.
  logic      src_rx;    // Receive rate source pulse.
  logic      half_rx;   // Receive rate halved.
  logic      tick_rx;   // Receive sixteenth-bit tick.
  logic      rx_fin;    // Last receive sample taken.
  logic      rx_ok;     // Finished frame is accepted.
  logic      phase;     // Shift clock phase in shift mode.
  logic [7:0] rx_data;  // Data byte of a finished frame.

  // Picks the rate source and whether it is halved.
  function automatic logic [1:0] pace(input uat_mode_t m, input logic sel2,
                                      input logic o2, input logic o1, input logic sm);
    logic var_rt;
    var_rt = (m == UAT_M_A8) || (m == UAT_M_V9);
    if (!var_rt) begin
      pace = {1'b1, ~sm};
    end else if (sel2) begin
      pace = {o2, 1'b0};
    end else begin
      pace = {o1, ~sm};
    end
  endfunction

  // Pins cross into the clock domain here.
  uat_sync u_sync (
    .mclk    (mclk),
    .nrst    (nrst),
    .ce      (ce),
    .pin_in  (pins),
    .pin_out (pin_s)
  );

  // Timer 2 sees falling edges only.
  uat_timer2 u_t2 (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .bus      (sfr),
    .ext_fall (ext_fall),
    .cnt_fall (cnt_fall),
    .t2       (t2)
  );

  // Every output is a flip-flop of the state.
  assign sfr_rdata  = s_ff.rdata;
  assign txd_out    = s_ff.txd;
  assign rxd_out    = s_ff.rxd_o;
  assign rxd_oe     = s_ff.rxd_oe;
  assign irq_serial = s_ff.irq_ser;
  assign irq_timer2 = s_ff.irq_t2;

  // Edge detection, rate ticks, both engines, bus access and pin drive.
  always_comb begin
    nxt_s = s_ff;
    rx_fin = 1'b0;
    rx_ok = 1'b0;
    mode = uat_mode_t'(s_ff.serial_control[`UAT_SC_MHI:`UAT_SC_MLO]);
    m0 = (mode == UAT_M_SHIFT);
    nine = (mode == UAT_M_F9) || (mode == UAT_M_V9);
    stop_at = nine ? `UAT_STOP9 : `UAT_STOP8;
    // A falling edge is a high sample followed by a low one.
    ext_fall = s_ff.pin_prev.ext & ~pin_s.ext;
    cnt_fall = s_ff.pin_prev.t2in & ~pin_s.t2in;
    nxt_s.pin_prev = pin_s;
    wr_serial_control = sfr.wr && (sfr.addr == `UAT_A_SERIAL_CONTROL);
    wr_serial_buffer = sfr.wr && (sfr.addr == `UAT_A_SERIAL_BUFFER);

    // Each direction has its own rate divider.
    {src_tx, half_tx} = pace(mode, t2.con[`UAT_T2_TXB], t2.ovf, t1_ovf, smod);
    {src_rx, half_rx} = pace(mode, t2.con[`UAT_T2_RXB], t2.ovf, t1_ovf, smod);
    tick_tx = src_tx & (~half_tx | s_ff.tx_half);
    tick_rx = src_rx & (~half_rx | s_ff.rx_half);
    if (src_tx) begin
      nxt_s.tx_half = ~s_ff.tx_half;
    end
    if (src_rx) begin
      nxt_s.rx_half = ~s_ff.rx_half;
    end

    // Software writes come first so hardware flag sets win.
    if (wr_serial_control) begin
      nxt_s.serial_control = sfr.wdata;
    end

    // Transmit engine, independent of the receive engine.
    if (s_ff.tx_busy) begin
      if (m0) begin
        // Two clocks per bit: shift clock low, then high.
        nxt_s.tx_sub[0] = ~s_ff.tx_sub[0];
        if (s_ff.tx_sub[0]) begin
          nxt_s.txsh = {1'b1, s_ff.txsh[10:1]};
          nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
          if (s_ff.tx_bit == `UAT_M0_LAST) begin
            nxt_s.tx_busy = 1'b0;
            nxt_s.serial_control[`UAT_SC_TXDONE] = 1'b1;
          end
        end
      end else if (tick_tx) begin
        nxt_s.tx_sub = s_ff.tx_sub + 4'h1;
        if (s_ff.tx_sub == `UAT_SUB_LAST) begin
          // Shift in ones so the line rests high after the stop bit.
          nxt_s.txsh = {1'b1, s_ff.txsh[10:1]};
          nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
          if (s_ff.tx_bit == stop_at) begin
            nxt_s.tx_busy = 1'b0;
          end
          if (nxt_s.tx_bit == stop_at) begin
            nxt_s.serial_control[`UAT_SC_TXDONE] = 1'b1;
          end
        end
      end
    end

    // A buffer write loads the frame and restarts the transmitter.
    if (wr_serial_buffer) begin
      nxt_s.tx_busy = 1'b1;
      nxt_s.tx_bit = 4'h0;
      nxt_s.tx_sub = 4'h0;
      if (m0) begin
        nxt_s.txsh = {3'b111, sfr.wdata};
      end else begin
        // Stop, ninth bit (the only stop bit sent in 8-bit mode), data, start.
        nxt_s.txsh = {1'b1, nine ? s_ff.serial_control[`UAT_SC_TX9] : 1'b1, sfr.wdata, 1'b0};
      end
    end

    // Receive engine; clearing the enable aborts any frame in progress.
    if (!s_ff.serial_control[`UAT_SC_RXEN]) begin
      nxt_s.rx_busy = 1'b0;
    end else if (s_ff.rx_busy) begin
      if (m0) begin
        nxt_s.rx_sub[0] = ~s_ff.rx_sub[0];
        if (s_ff.rx_sub[0]) begin
          nxt_s.rxsh = {pin_s.rxd, s_ff.rxsh[8:1]};
          nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
          if (s_ff.rx_bit == `UAT_M0_LAST) begin
            rx_fin = 1'b1;
            nxt_s.rx_busy = 1'b0;
          end
        end
      end else if (tick_rx) begin
        nxt_s.rx_sub = s_ff.rx_sub + 4'h1;
        // Sample at the middle of each bit.
        if (s_ff.rx_sub == `UAT_SUB_MID) begin
          nxt_s.rx_bit = s_ff.rx_bit + 4'h1;
          if (s_ff.rx_bit == 4'h0) begin
            // A start bit that is high again at mid-bit was noise.
            if (pin_s.rxd) begin
              nxt_s.rx_busy = 1'b0;
            end
          end else if (s_ff.rx_bit == stop_at) begin
            rx_fin = 1'b1;
            nxt_s.rx_busy = 1'b0;
          end else begin
            nxt_s.rxsh = {pin_s.rxd, s_ff.rxsh[8:1]};
          end
        end
      end
    end else if (m0 ? (~s_ff.serial_control[`UAT_SC_RXDONE] & ~s_ff.tx_busy)
                    : (s_ff.pin_prev.rxd & ~pin_s.rxd)) begin
      nxt_s.rx_busy = 1'b1;
      nxt_s.rx_bit = 4'h0;
      nxt_s.rx_sub = 4'h0;
    end

    // Nine-bit frames hold data in the low byte, others one place up.
    rx_data = nine ? nxt_s.rxsh[7:0] : nxt_s.rxsh[8:1];
    if (rx_fin) begin
      if (m0 || !s_ff.serial_control[`UAT_SC_MP]) begin
        rx_ok = 1'b1;
      end else if (nine) begin
        rx_ok = s_ff.rxsh[8];
      end else begin
        rx_ok = pin_s.rxd;
      end
    end
    // An unread byte is simply overwritten; no overrun flag exists.
    if (rx_ok) begin
      nxt_s.rxbuf = rx_data;
      nxt_s.serial_control[`UAT_SC_RXDONE] = 1'b1;
      if (!m0) begin
        nxt_s.serial_control[`UAT_SC_RX9] = nine ? s_ff.rxsh[8] : pin_s.rxd;
      end
    end

    // Shift mode drives data on the serial pin and the clock on the transmit pin.
    phase = nxt_s.tx_busy ? nxt_s.tx_sub[0] : nxt_s.rx_sub[0];
    nxt_s.rxd_oe = m0 & nxt_s.tx_busy;
    nxt_s.rxd_o = nxt_s.txsh[0];
    if (m0) begin
      nxt_s.txd = ~(nxt_s.tx_busy | nxt_s.rx_busy) | phase;
    end else begin
      nxt_s.txd = ~nxt_s.tx_busy | nxt_s.txsh[0];
    end

    // Registered read data, one cycle after the read strobe.
    if (sfr.rd) begin
      if (sfr.addr == `UAT_A_SERIAL_CONTROL) begin
        nxt_s.rdata = s_ff.serial_control;
      end else if (sfr.addr == `UAT_A_SERIAL_BUFFER) begin
        nxt_s.rdata = s_ff.rxbuf;
      end else if (sfr.addr == `UAT_A_T2CTL) begin
        nxt_s.rdata = t2.con;
      end else if (sfr.addr == `UAT_A_RCAPL) begin
        nxt_s.rdata = t2.rcap[7:0];
      end else if (sfr.addr == `UAT_A_RCAPH) begin
        nxt_s.rdata = t2.rcap[15:8];
      end else if (sfr.addr == `UAT_A_CNTL) begin
        nxt_s.rdata = t2.cnt[7:0];
      end else if (sfr.addr == `UAT_A_CNTH) begin
        nxt_s.rdata = t2.cnt[15:8];
      end else begin
        nxt_s.rdata = 8'h00;
      end
    end

    // The serial request rises with its flags; the Timer 2 request follows its flags by one cycle.
    nxt_s.irq_ser = nxt_s.serial_control[`UAT_SC_TXDONE] | nxt_s.serial_control[`UAT_SC_RXDONE];
    nxt_s.irq_t2 = t2.con[`UAT_T2_OVF] | t2.con[`UAT_T2_EXT];
  end

  // State register; the idle lines reset high.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
      s_ff.serial_control <= `UAT_RST_SERIAL_CONTROL;
      s_ff.pin_prev <= '1;
      s_ff.txd <= 1'b1;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  default clocking dc @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_serial_buffer_start: assert property (ce && wr_serial_buffer |=> s_ff.tx_busy && s_ff.tx_bit == 4'h0)
    else $error("buffer write did not start transmit");
  chk_start_low: assert property (ce && wr_serial_buffer && !m0 |=> !txd_out)
    else $error("start bit not low");
  chk_done_stop: assert property (ce && !m0 && !wr_serial_control && !s_ff.serial_control[1] ##1 s_ff.serial_control[1] |-> txd_out)
    else $error("transmit done not at stop bit");
  chk_ren_off: assert property (ce && !s_ff.serial_control[`UAT_SC_RXEN] |=> !s_ff.rx_busy)
    else $error("receiver busy while disabled");
  chk_m0_rx_go: assert property (ce && m0 && s_ff.serial_control[4] && !s_ff.serial_control[0] && !s_ff.rx_busy && !s_ff.tx_busy
                                 |=> s_ff.rx_busy)
    else $error("shift receive did not start");
  chk_mp_drop: assert property (ce && rx_fin && nine && s_ff.serial_control[5] && !s_ff.rxsh[8] && !wr_serial_control && !s_ff.serial_control[0]
                                |=> !s_ff.serial_control[0])
    else $error("address filter let frame through");
  chk_rx_overwrite: assert property (ce && rx_ok |=> s_ff.rxbuf == $past(rx_data) && s_ff.serial_control[0])
    else $error("received byte not stored");
  chk_rx_mid_stop: assert property (ce && !m0 && rx_ok |-> s_ff.rx_sub == 4'h7)
    else $error("receive done not at mid stop");
  cov_tx_done: cover property (ce && !m0 && !s_ff.serial_control[1] ##1 s_ff.serial_control[1]);
  cov_rx_frame: cover property (ce && rx_ok && nine);
  cov_duplex: cover property (s_ff.tx_busy && s_ff.rx_busy && !m0);
endmodule

//--- verification/tb_uat_top.sv
// Self-checking bench for the serial port and its Timer 2.
`timescale 1ns/1ps
`include "uat_params.svh"
module tb_uat_top import uat_pkg::*; ;
  logic       mclk;
  logic       nrst;
  uat_bus_t   sfr;
  uat_pins_t  pins;
  logic       node_rxd;
  logic       ext_pin;
  logic       nine;
  logic [7:0] sfr_rdata;
  logic       txd_out;
  logic       rxd_out;
  logic       rxd_oe;
  logic       irq_serial;
  logic       irq_timer2;
  logic [8:0] got_data;
  logic       got_stop;
  int         got_cnt;
  int         bad_count;
  int         total_checks;
  int         cycles;
  logic [7:0] rv;

  // Timer 2 reloads 0xFFFF, so sixteen overflows give a 32-cycle bit.
  assign pins = '{rxd: node_rxd, ext: ext_pin, t2in: 1'b1};

  uat_top i_uat_top (.mclk(mclk), .nrst(nrst), .ce(1'b1), .sfr(sfr), .t1_ovf(1'b0), .smod(1'b0),
    .pins(pins), .sfr_rdata(sfr_rdata), .txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
    .irq_serial(irq_serial), .irq_timer2(irq_timer2));

  uat_remote_node #(.BIT_CLKS(32)) i_uat_remote_node (.mclk(mclk), .txd(txd_out), .nine(nine),
    .rxd(node_rxd), .got_data(got_data), .got_stop(got_stop), .got_cnt(got_cnt));

  // Half period of 50 ns gives the 10 MHz core clock.
  always #50 mclk = ~mclk;

  // Cuts a hung run short; the tests need well under this many cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 40000) begin
      bad_count++;
      conclude();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // One-cycle write strobe, taken at the edge after it is raised.
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) sfr <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge mclk) sfr.wr <= 1'b0;
  endtask

  // Read data is settled in the cycle after the taking edge.
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk) sfr <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge mclk) sfr.rd <= 1'b0;
    @(negedge mclk) d = sfr_rdata;
  endtask

  // Starts a transmit and waits, bounded, until the node has decoded the frame.
  task automatic send_byte(input logic [7:0] d);
    int c0;
    c0 = got_cnt;
    wr_reg(`UAT_A_SERIAL_BUFFER, d);
    for (int i = 0; i < 800 && got_cnt == c0; i++) @(posedge mclk);
    repeat (4) @(posedge mclk);
  endtask

  task automatic rx_frame(input logic [8:0] d, input logic nb, input logic stop);
    i_uat_remote_node.send_frame(d, nb, stop);
    repeat (8) @(posedge mclk);
  endtask

  task automatic ext_edge;
    @(posedge mclk) ext_pin <= 1'b0;
    repeat (6) @(posedge mclk);
    ext_pin <= 1'b1;
    repeat (6) @(posedge mclk);
  endtask

  // Main sequence of register calls and frames.
  initial begin
    mclk = 1'b0;
    nrst = 1'b0;
    sfr = '0;
    ext_pin = 1'b1;
    nine = 1'b0;
    bad_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv, `UAT_RST_SERIAL_CONTROL);
    rd_reg(`UAT_A_T2CTL, rv); check(rv, `UAT_RST_T2CTL);
    rd_reg(8'h55, rv); check(rv, 8'h00);
    wr_reg(`UAT_A_RCAPL, 8'hFF);
    wr_reg(`UAT_A_RCAPH, 8'hFF);
    // The count resets to zero, so preset it too or the first overflow is 65536 steps away.
    wr_reg(`UAT_A_CNTL, 8'hFF);
    wr_reg(`UAT_A_CNTH, 8'hFF);
    wr_reg(`UAT_A_T2CTL, 8'h34);
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'h50);
    // Both directions at once in 8-bit framing.
    fork
      rx_frame(9'h03C, 1'b0, 1'b1);
      send_byte(8'hA5);
    join
    check(got_data, 9'h0A5);
    check(got_stop, 1'b1);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv, 8'h57);
    rd_reg(`UAT_A_SERIAL_BUFFER, rv); check(rv, 8'h3C);
    rd_reg(`UAT_A_T2CTL, rv); check(rv, 8'h34);
    // The second unread byte replaces the first.
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'h50);
    rx_frame(9'h011, 1'b0, 1'b1);
    rx_frame(9'h022, 1'b0, 1'b1);
    rd_reg(`UAT_A_SERIAL_BUFFER, rv); check(rv, 8'h22);
    // Multiprocessor filter in 8-bit framing drops a zero stop bit.
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'h70);
    rx_frame(9'h044, 1'b0, 1'b0);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv[0], 1'b0);
    rx_frame(9'h045, 1'b0, 1'b1);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv[0], 1'b1);
    // 9-bit filter drops frames whose ninth bit is zero.
    nine = 1'b1;
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'hF0);
    rx_frame(9'h066, 1'b1, 1'b1);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv, 8'hF0);
    rx_frame(9'h167, 1'b1, 1'b1);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv, 8'hF5);
    rd_reg(`UAT_A_SERIAL_BUFFER, rv); check(rv, 8'h67);
    // Receiver disabled while a frame arrives; transmit still sends the ninth bit.
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'hC8);
    fork
      rx_frame(9'h199, 1'b1, 1'b1);
      send_byte(8'h5A);
    join
    check(got_data, 9'h15A);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv); check(rv, 8'hCA);
    // Every framed mode, each with its own ninth bit choice.
    for (int m = 1; m < 4; m++) begin
      nine = (m > 1);
      wr_reg(`UAT_A_SERIAL_CONTROL, 8'((m << 6) | (m[0] ? 8'h00 : 8'h08)));
      send_byte(8'h0F + 8'(m));
      check(got_data, {nine & ~m[0], 8'h0F + 8'(m)});
    end
    // Shift register mode: data leaves on the serial pin, then an idle line is shifted in.
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'h00);
    wr_reg(`UAT_A_SERIAL_BUFFER, 8'h5A);
    @(negedge mclk);
    check(rxd_oe, 1'b1);
    check(rxd_out, 1'b0);
    repeat (24) @(posedge mclk);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv);
    check(rv, 8'h02);
    check(irq_serial, 1'b1);
    wr_reg(`UAT_A_SERIAL_CONTROL, 8'h10);
    repeat (24) @(posedge mclk);
    rd_reg(`UAT_A_SERIAL_CONTROL, rv);
    check(rv, 8'h11);
    rd_reg(`UAT_A_SERIAL_BUFFER, rv);
    check(rv, 8'hFF);
    // Trigger flag still works in baud generator mode.
    wr_reg(`UAT_A_T2CTL, 8'h3C);
    ext_edge();
    rd_reg(`UAT_A_T2CTL, rv); check(rv, 8'h7C);
    check(irq_timer2, 1'b1);
    // Capture copies the running count, then an overflow sets the flag.
    // Clear the low byte first so the captured high byte cannot have carried to one.
    wr_reg(`UAT_A_CNTL, 8'h00);
    wr_reg(`UAT_A_CNTH, 8'h00);
    wr_reg(`UAT_A_T2CTL, 8'h0D);
    ext_edge();
    rd_reg(`UAT_A_T2CTL, rv); check(rv, 8'h4D);
    rd_reg(`UAT_A_RCAPH, rv); check(rv, 8'h00);
    wr_reg(`UAT_A_CNTH, 8'hFF);
    wr_reg(`UAT_A_CNTL, 8'hFE);
    repeat (200) @(posedge mclk);
    rd_reg(`UAT_A_T2CTL, rv); check(rv, 8'hCD);
    // Autoreload loads the reload pair on rollover.
    wr_reg(`UAT_A_RCAPH, 8'h12);
    wr_reg(`UAT_A_RCAPL, 8'h00);
    wr_reg(`UAT_A_T2CTL, 8'h04);
    wr_reg(`UAT_A_CNTH, 8'hFF);
    wr_reg(`UAT_A_CNTL, 8'hFE);
    repeat (200) @(posedge mclk);
    rd_reg(`UAT_A_T2CTL, rv); check(rv, 8'h84);
    rd_reg(`UAT_A_CNTH, rv); check(rv, 8'h12);
    // A trigger edge in autoreload mode reloads the count at once.
    wr_reg(`UAT_A_T2CTL, 8'h0C);
    wr_reg(`UAT_A_CNTH, 8'h55);
    ext_edge();
    rd_reg(`UAT_A_T2CTL, rv);
    check(rv, 8'h4C);
    rd_reg(`UAT_A_CNTH, rv);
    check(rv, 8'h12);
    conclude();
  end
endmodule

//--- verification/uat_remote_node.sv
// Remote serial node that sends frames to the port and decodes frames from it.
`timescale 1ns/1ps
module uat_remote_node #(
  parameter int BIT_CLKS = 32
) (
  input  wire logic  mclk,
  input  wire logic  txd,
  input  wire logic  nine,
  output logic       rxd,
  output logic [8:0] got_data,
  output logic       got_stop,
  output int         got_cnt
);
  // The line idles high between frames, as a real node leaves it.
  initial begin
    rxd = 1'b1;
    got_data = '0;
    got_stop = 1'b0;
    got_cnt = 0;
  end

  // Sends one frame; a zero stop bit is sent only where a test asks for a broken frame.
  task automatic send_frame(input logic [8:0] d, input logic nine_bits, input logic stop);
    @(posedge mclk) rxd <= 1'b0;
    for (int i = 0; i < (nine_bits ? 9 : 8); i++) begin
      repeat (BIT_CLKS) @(posedge mclk);
      rxd <= d[i];
    end
    repeat (BIT_CLKS) @(posedge mclk);
    rxd <= stop;
    repeat (BIT_CLKS) @(posedge mclk);
    rxd <= 1'b1;
  endtask

  // Decodes each frame at mid bit, counting from the falling start edge.
  always begin
    @(negedge txd);
    got_data = '0;
    repeat (BIT_CLKS / 2) @(posedge mclk);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CLKS) @(posedge mclk);
      got_data[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge mclk);
    got_stop = txd;
    got_cnt++;
  end
endmodule
